// ===== hdl/atc_pkg.sv
// package: register map, field positions, reset values and timing for the converter control slice
`default_nettype none
package atc_pkg;
    localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
    localparam logic [3:0] OFS_CTRL_THREE = 4'h2;
    localparam logic [3:0] OFS_PIN_LOW = 4'h3;
    localparam logic [3:0] OFS_PIN_MID = 4'h4;
    localparam logic [3:0] OFS_RESULT_LO = 4'h5;
    localparam logic [3:0] OFS_RESULT_HI = 4'h6;
    localparam logic [3:0] OFS_CMPV_LO = 4'h7;
    localparam logic [3:0] OFS_CMPV_HI = 4'h8;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h9;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hA;
    localparam int BIT_ACTIVE = 7;
    localparam int BIT_TRIG_SEL = 6;
    localparam int BIT_CMP_EN = 5;
    localparam int BIT_CMP_GE = 4;
    localparam int BIT_CONT_EN = 3;
    localparam int BIT_CHAN_OFF = 7;
    localparam logic [7:0] CTRL_TWO_WMASK = 8'h74;
    localparam logic [7:0] CTRL_THREE_WMASK = 8'h08;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CTRL_ONE = 8'h80;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CMP = 1;
    localparam int IRQ_ABORT = 2;
    localparam int IRQ_BITS = 3;
    localparam int CLK_MHZ = 125;
    localparam int CONV_TIME_NS = 2500;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {ATC_IDLE, ATC_CONV, ATC_DONE} atc_state_t;
endpackage
`default_nettype wire

// ===== hdl/atc_compare.sv
// result comparator: less-than or greater-or-equal against the compare value
`default_nettype none
module atc_compare #(
    parameter int WIDTH = 12
) (
    input wire logic [WIDTH-1:0] result,
    input wire logic [WIDTH-1:0] compare_value,
    input wire logic compare_greater_equal,
    output logic hit
);
    always_comb begin
        if (compare_greater_equal) begin
            hit = (result >= compare_value);
        end else begin
            hit = (result < compare_value);
        end
    end
endmodule
`default_nettype wire

// ===== hdl/atc_top.sv
// conversion control, trigger, compare, pin detach and interrupt logic of the converter slice
//
// What this block does
// - conversion_active bit 7 sets at conversion start, clears one cycle after a non-continuous finish, or on abort.
// - trigger_select 0: a write to conversion_control_one with bit 7 zero starts a conversion.
// - trigger_select 1: hardware_trigger_in starts conversions, register writes do not.
// - result compare runs only while compare_enable bit 5 is one.
// - compare_greater_equal one: compare true when result >= compare value.
// - compare_greater_equal zero: compare true only when result < compare value.
// - continuous_enable bit 3 zero: one conversion per start; one: keep converting.
// - reserved bits of conversion_control_three written zero; only bit 3 functions.
// - analog_pin_select_low bit n detaches analog channel n, channels 0-7.
// - analog_pin_select_mid bit n detaches analog channel n+8, channels 8-15.
// - pin-control bit zero keeps port control; one disables port control.
// - detached pin: output hi-z, input buffer and pullup off, port reads zero.
// - hardware mode starts on rising trigger edge; edges during conversion ignored.
// - continuous mode restarts after each result; only first hardware edge launches.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`default_nettype none
module atc_top #(
    parameter int RES_WIDTH = 12,
    parameter int NUM_CHAN = 16,
    parameter int CONV_CYCLES = atc_pkg::CONV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic hardware_trigger_in,
    input wire logic [RES_WIDTH-1:0] analog_result,
    output logic sample_strobe,
    output logic [4:0] channel_select,
    input wire logic [NUM_CHAN-1:0] port_out_data,
    input wire logic [NUM_CHAN-1:0] port_out_enable,
    input wire logic [NUM_CHAN-1:0] port_pullup_enable,
    input wire logic [NUM_CHAN-1:0] pin_in_level,
    output logic [NUM_CHAN-1:0] pin_out,
    output logic [NUM_CHAN-1:0] pin_oe,
    output logic [NUM_CHAN-1:0] pin_pullup,
    output logic [NUM_CHAN-1:0] pin_input_enable,
    output logic [NUM_CHAN-1:0] port_read_data,
    output logic compare_hit,
    output logic irq
);
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] ctrl_one_reg;
    logic [7:0] ctrl_one_next;
    logic [7:0] ctrl_two_reg;
    logic [7:0] ctrl_two_next;
    logic [7:0] ctrl_three_reg;
    logic [7:0] ctrl_three_next;
    logic [7:0] pin_low_reg;
    logic [7:0] pin_low_next;
    logic [7:0] pin_mid_reg;
    logic [7:0] pin_mid_next;
    logic [RES_WIDTH-1:0] result_reg;
    logic [RES_WIDTH-1:0] result_next;
    logic [RES_WIDTH-1:0] cmpv_reg;
    logic [RES_WIDTH-1:0] cmpv_next;
    logic [atc_pkg::IRQ_BITS-1:0] irq_status_reg;
    logic [atc_pkg::IRQ_BITS-1:0] irq_status_next;
    logic [atc_pkg::IRQ_BITS-1:0] irq_mask_reg;
    logic [atc_pkg::IRQ_BITS-1:0] irq_mask_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////////
    // conversion engine state
    atc_pkg::atc_state_t state_reg;
    atc_pkg::atc_state_t state_next;
    // wide enough for microsecond conversions at a fast bus clock
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic trig_prev_reg;
    logic trig_prev_next;
    logic hit_reg;
    logic hit_next;

    ////////////////////////////////////////////////////////////////////////////
    // decoded controls and events
    logic trig_sel;
    logic cont_en;
    logic wr_one;
    logic trig_rise;
    logic start_req;
    logic finish;
    logic abort_req;
    logic raw_hit;
    logic [7:0] rd_mux;

    assign trig_sel = ctrl_two_reg[atc_pkg::BIT_TRIG_SEL];
    assign cont_en = ctrl_three_reg[atc_pkg::BIT_CONT_EN];
    assign wr_one = reg_wr && (reg_addr == atc_pkg::OFS_CTRL_ONE);
    // hardware trigger is taken as synchronous, so a plain edge detector suffices
    assign trig_rise = hardware_trigger_in && !trig_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // compare
    atc_compare #(
        .WIDTH(RES_WIDTH)
    ) u_compare (
        .result(analog_result),
        .compare_value(cmpv_reg),
        .compare_greater_equal(ctrl_two_reg[atc_pkg::BIT_CMP_GE]),
        .hit(raw_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // conversion control
    always_comb begin
        start_req = 1'b0;
        abort_req = 1'b0;
        if (wr_one) begin
            // any write to control one ends a running conversion
            abort_req = (state_reg != atc_pkg::ATC_IDLE);
            if (!trig_sel && !reg_wdata[atc_pkg::BIT_CHAN_OFF]) begin
                start_req = 1'b1;
            end
        end else if (trig_sel && trig_rise && state_reg == atc_pkg::ATC_IDLE) begin
            start_req = 1'b1;
        end
    end

    assign finish = (state_reg == atc_pkg::ATC_CONV) && (count_reg == CONV_LAST);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        trig_prev_next = hardware_trigger_in;
        hit_next = hit_reg;
        if (start_req) begin
            state_next = atc_pkg::ATC_CONV;
            count_next = 16'h0000;
        end else if (abort_req) begin
            state_next = atc_pkg::ATC_IDLE;
        end else begin
            unique case (state_reg)
                atc_pkg::ATC_IDLE: begin
                end
                atc_pkg::ATC_CONV: begin
                    count_next = count_reg + 16'h0001;
                    if (finish) begin
                        state_next = atc_pkg::ATC_DONE;
                    end
                end
                atc_pkg::ATC_DONE: begin
                    // hardware edges are ignored here: restarts come from continuous mode or a software start write to control one
                    if (cont_en) begin
                        state_next = atc_pkg::ATC_CONV;
                        count_next = 16'h0000;
                    end else begin
                        state_next = atc_pkg::ATC_IDLE;
                    end
                end
                default: begin
                    state_next = atc_pkg::ATC_IDLE;
                end
            endcase
        end
        if (finish) begin
            hit_next = ctrl_two_reg[atc_pkg::BIT_CMP_EN] && raw_hit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= atc_pkg::ATC_IDLE;
            count_reg <= 16'h0000;
            trig_prev_reg <= 1'b0;
            hit_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            trig_prev_reg <= trig_prev_next;
            hit_reg <= hit_next;
        end
    end

    assign sample_strobe = finish;
    assign channel_select = ctrl_one_reg[4:0];
    assign compare_hit = hit_reg;

    ////////////////////////////////////////////////////////////////////////////
    // registers and interrupt status
    always_comb begin
        logic [atc_pkg::IRQ_BITS-1:0] ev;
        ev = '0;
        ctrl_one_next = ctrl_one_reg;
        ctrl_two_next = ctrl_two_reg;
        ctrl_three_next = ctrl_three_reg;
        pin_low_next = pin_low_reg;
        pin_mid_next = pin_mid_reg;
        result_next = result_reg;
        cmpv_next = cmpv_reg;
        irq_mask_next = irq_mask_reg;
        irq_status_next = irq_status_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                atc_pkg::OFS_CTRL_ONE: begin
                    ctrl_one_next = reg_wdata;
                end
                // reserved bits and the active flag are masked off on write
                atc_pkg::OFS_CTRL_TWO: begin
                    ctrl_two_next = reg_wdata & atc_pkg::CTRL_TWO_WMASK;
                end
                atc_pkg::OFS_CTRL_THREE: begin
                    ctrl_three_next = reg_wdata & atc_pkg::CTRL_THREE_WMASK;
                end
                atc_pkg::OFS_PIN_LOW: begin
                    pin_low_next = reg_wdata;
                end
                atc_pkg::OFS_PIN_MID: begin
                    pin_mid_next = reg_wdata;
                end
                atc_pkg::OFS_CMPV_LO: begin
                    cmpv_next[7:0] = reg_wdata;
                end
                // upper write bits beyond the result width are dropped
                atc_pkg::OFS_CMPV_HI: begin
                    cmpv_next[RES_WIDTH-1:8] = reg_wdata[RES_WIDTH-9:0];
                end
                // only a written one clears a status bit, reads have no side effect
                atc_pkg::OFS_IRQ_STATUS: begin
                    irq_status_next = irq_status_reg & ~reg_wdata[atc_pkg::IRQ_BITS-1:0];
                end
                atc_pkg::OFS_IRQ_MASK: begin
                    irq_mask_next = reg_wdata[atc_pkg::IRQ_BITS-1:0];
                end
                default: begin
                end
            endcase
        end

        if (finish) begin
            result_next = analog_result;
            ev[atc_pkg::IRQ_DONE] = 1'b1;
            ev[atc_pkg::IRQ_CMP] = ctrl_two_reg[atc_pkg::BIT_CMP_EN] && raw_hit;
        end
        ev[atc_pkg::IRQ_ABORT] = abort_req && !start_req;
        // set wins over a clear in the same cycle
        irq_status_next = irq_status_next | ev;
    end


    ////////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            atc_pkg::OFS_CTRL_ONE: begin
                rd_mux = ctrl_one_reg;
            end
            // the active flag is live state, not a stored bit
            atc_pkg::OFS_CTRL_TWO: begin
                rd_mux = ctrl_two_reg;
                rd_mux[atc_pkg::BIT_ACTIVE] = (state_reg != atc_pkg::ATC_IDLE);
            end
            atc_pkg::OFS_CTRL_THREE: begin
                rd_mux = ctrl_three_reg;
            end
            atc_pkg::OFS_PIN_LOW: begin
                rd_mux = pin_low_reg;
            end
            atc_pkg::OFS_PIN_MID: begin
                rd_mux = pin_mid_reg;
            end
            atc_pkg::OFS_RESULT_LO: begin
                rd_mux = result_reg[7:0];
            end
            atc_pkg::OFS_RESULT_HI: begin
                rd_mux = 8'(result_reg[RES_WIDTH-1:8]);
            end
            atc_pkg::OFS_CMPV_LO: begin
                rd_mux = cmpv_reg[7:0];
            end
            atc_pkg::OFS_CMPV_HI: begin
                rd_mux = 8'(cmpv_reg[RES_WIDTH-1:8]);
            end
            atc_pkg::OFS_IRQ_STATUS: begin
                rd_mux = 8'(irq_status_reg);
            end
            atc_pkg::OFS_IRQ_MASK: begin
                rd_mux = 8'(irq_mask_reg);
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
        // idle bus reads as zero so a wired-or bus needs no extra gating
        rdata_next = reg_rd ? rd_mux : 8'h00;
    end


    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_one_reg <= atc_pkg::RST_CTRL_ONE;
            ctrl_two_reg <= atc_pkg::RST_BYTE;
            ctrl_three_reg <= atc_pkg::RST_BYTE;
            pin_low_reg <= atc_pkg::RST_BYTE;
            pin_mid_reg <= atc_pkg::RST_BYTE;
            result_reg <= '0;
            cmpv_reg <= '0;
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_one_reg <= ctrl_one_next;
            ctrl_two_reg <= ctrl_two_next;
            ctrl_three_reg <= ctrl_three_next;
            pin_low_reg <= pin_low_next;
            pin_mid_reg <= pin_mid_next;
            result_reg <= result_next;
            cmpv_reg <= cmpv_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // pin detach per channel
    logic [15:0] detach;
    assign detach = {pin_mid_reg, pin_low_reg};

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_pin
            // detached pins float so the analog input sees no digital load
            assign pin_oe[ch] = port_out_enable[ch] && !detach[ch];
            assign pin_out[ch] = port_out_data[ch] && !detach[ch];
            assign pin_pullup[ch] = port_pullup_enable[ch] && !detach[ch];
            assign pin_input_enable[ch] = !detach[ch];
            assign port_read_data[ch] = pin_in_level[ch] && !detach[ch];
        end
    endgenerate
endmodule
`default_nettype wire

// ===== verif/atc_checker_assertions.sv
// checker: readback, pin gating and conversion timing seen at the block ports
`default_nettype none
module atc_checker #(
    parameter int NUM_CHAN = 16,
    parameter int CONV_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sample_strobe,
    input wire logic [NUM_CHAN-1:0] port_out_enable,
    input wire logic [NUM_CHAN-1:0] pin_oe,
    input wire logic [NUM_CHAN-1:0] pin_in_level,
    input wire logic [NUM_CHAN-1:0] port_read_data
);
    localparam int GAP = CONV_CYCLES + 1;
    logic [3:0] mode_reg;
    logic [3:0] mode_next;
    logic ctl0_wr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of trigger, compare and continuous bits, built from bus writes only
    assign ctl0_wr = reg_wr && reg_addr == atc_pkg::OFS_CTRL_ONE;
    always_comb begin
        mode_next = mode_reg;
        if (reg_wr && reg_addr == atc_pkg::OFS_CTRL_TWO) begin
            mode_next[3:1] = reg_wdata[6:4];
        end
        if (reg_wr && reg_addr == atc_pkg::OFS_CTRL_THREE) begin
            mode_next[0] = reg_wdata[3];
        end
    end
    always_ff @(posedge clk_sys) begin
        mode_reg <= sys_rst ? 4'h0 : mode_next;
    end
    ////////////////////////////////////////////////////////////////////////////////
    two_readback_a: assert property (
        reg_rd && reg_addr == atc_pkg::OFS_CTRL_TWO |=>
            reg_rdata[6:4] == mode_reg[3:1] && reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'b00)
        else $error("control two readback wrong");
    three_readback_a: assert property (
        reg_rd && reg_addr == atc_pkg::OFS_CTRL_THREE |=> reg_rdata == {4'h0, mode_reg[0], 3'h0})
        else $error("control three readback wrong");
    read_gate_a: assert property ((port_read_data & ~pin_in_level) == '0)
        else $error("port read shows a level the pin lacks");
    oe_gate_a: assert property ((pin_oe & ~port_out_enable) == '0)
        else $error("pin driven without port enable");
    sw_start_a: assert property (
        ctl0_wr && !reg_wdata[7] && !mode_reg[3] |-> ##CONV_CYCLES sample_strobe)
        else $error("software start missed its sample");
    hw_nostart_a: assert property (ctl0_wr && mode_reg[3] |-> ##CONV_CYCLES !sample_strobe)
        else $error("register write started a hardware mode conversion");
    strobe_spacing_a: assert property (sample_strobe |=> !sample_strobe [*4])
        else $error("samples closer than one conversion");
    cont_restart_a: assert property (sample_strobe && mode_reg[0] |-> ##GAP sample_strobe)
        else $error("continuous mode did not restart");
endmodule
`default_nettype wire

// ===== verif/atc_analog_model.sv
// far-side model: converter core presenting its result only in the sample cycle
`default_nettype none
module atc_analog_model (
    input wire logic sample_strobe,
    input wire logic [11:0] level,
    output logic [11:0] analog_result
);
    // outside the sample cycle the inverse is shown, so an early or late capture is caught
    assign analog_result = sample_strobe ? level : ~level;
endmodule
`default_nettype wire

// ===== verif/atc_top_bench.sv
// testbench: registers, pins, compare, triggers, continuous mode and reset
`default_nettype none
module atc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 4;
    localparam int GAP = CONV + 1;
    localparam logic [7:0] CMP_MODE [5] = '{8'h00, 8'h30, 8'h30, 8'h20, 8'h20};
    localparam logic [11:0] CMP_RES [5] = '{12'h123, 12'h800, 12'h7FF, 12'h7FF, 12'h800};
    localparam logic [4:0] CMP_HIT = 5'b01010;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic hardware_trigger_in = 1'b0;
    logic [15:0] port_in = 16'hFFFF;
    logic [11:0] level = 12'h000;
    logic [7:0] reg_rdata;
    logic [11:0] analog_result;
    logic sample_strobe, compare_hit, irq;
    logic [15:0] pin_out, pin_oe, pin_pullup, pin_input_enable, port_read_data;
    int num_errors = 0;
    int samples_checked = 0;
    always #4 clk_sys = ~clk_sys;
    atc_top #(.CONV_CYCLES(CONV)) i_atc_top (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hardware_trigger_in(hardware_trigger_in),
        .analog_result(analog_result), .sample_strobe(sample_strobe), .channel_select(),
        .port_out_data(port_in), .port_out_enable(port_in), .port_pullup_enable(port_in), .pin_in_level(port_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_input_enable(pin_input_enable),
        .port_read_data(port_read_data), .compare_hit(compare_hit), .irq(irq));
    atc_analog_model i_atc_analog_model (.sample_strobe(sample_strobe), .level(level), .analog_result(analog_result));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wait_strobe;
        int n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (sample_strobe !== 1'b1 && n < 50);
        chk(16'(n < 50), 16'h0001);
    endtask
    task automatic count_strobes(output int cnt);
        cnt = 0;
        repeat (3 * GAP) begin
            @(negedge clk_sys);
            cnt += int'(sample_strobe);
        end
    endtask
    task automatic trig_pulse;
        @(posedge clk_sys);
        hardware_trigger_in <= 1'b1;
        @(posedge clk_sys);
        hardware_trigger_in <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        int cnt;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // set bits in reserved and status places must not stick
        wr(atc_pkg::OFS_CTRL_TWO, 8'hFF);
        rd(atc_pkg::OFS_CTRL_TWO, d);
        chk(16'(d), 16'h0074);
        wr(atc_pkg::OFS_CTRL_THREE, 8'hFF);
        rd(atc_pkg::OFS_CTRL_THREE, d);
        chk(16'(d), 16'h0008);
        wr(atc_pkg::OFS_CTRL_THREE, 8'h00);
        wr(atc_pkg::OFS_PIN_LOW, 8'h05);
        wr(atc_pkg::OFS_PIN_MID, 8'hA0);
        rd(atc_pkg::OFS_PIN_LOW, d);
        chk(16'(d), 16'h0005);
        rd(atc_pkg::OFS_PIN_MID, d);
        chk(16'(d), 16'h00A0);
        chk(pin_oe, 16'h5FFA);
        chk(pin_out, 16'h5FFA);
        chk(pin_pullup, 16'h5FFA);
        chk(pin_input_enable, 16'h5FFA);
        chk(port_read_data, 16'h5FFA);
        wr(atc_pkg::OFS_CMPV_LO, 8'h00);
        wr(atc_pkg::OFS_CMPV_HI, 8'h08);
        wr(atc_pkg::OFS_IRQ_MASK, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(atc_pkg::OFS_CTRL_TWO, CMP_MODE[i]);
            level <= CMP_RES[i];
            wr(atc_pkg::OFS_CTRL_ONE, 8'h00);
            rd(atc_pkg::OFS_CTRL_TWO, d);
            chk(16'(d[7]), 16'h0001);
            wait_strobe;
            rd(atc_pkg::OFS_RESULT_LO, d);
            chk(16'(d), 16'(CMP_RES[i][7:0]));
            rd(atc_pkg::OFS_RESULT_HI, d);
            chk(16'(d), 16'(CMP_RES[i][11:8]));
            chk(16'(compare_hit), 16'(CMP_HIT[i]));
            rd(atc_pkg::OFS_CTRL_TWO, d);
            chk(16'(d[7]), 16'h0000);
            chk(16'(irq), 16'h0001);
            wr(atc_pkg::OFS_IRQ_STATUS, 8'h07);
            @(negedge clk_sys);
            chk(16'(irq), 16'h0000);
        end
        // hardware mode: writes do not start, edges while busy are dropped, a write aborts
        wr(atc_pkg::OFS_CTRL_TWO, 8'h40);
        wr(atc_pkg::OFS_CTRL_ONE, 8'h00);
        count_strobes(cnt);
        chk(16'(cnt), 16'h0000);
        trig_pulse;
        trig_pulse;
        count_strobes(cnt);
        chk(16'(cnt), 16'h0001);
        trig_pulse;
        wr(atc_pkg::OFS_CTRL_ONE, 8'h00);
        count_strobes(cnt);
        chk(16'(cnt), 16'h0000);
        rd(atc_pkg::OFS_IRQ_STATUS, d);
        chk(16'(d[2]), 16'h0001);
        wr(atc_pkg::OFS_IRQ_STATUS, 8'h07);
        // continuous mode with the done event masked, then stopped by reset
        wr(atc_pkg::OFS_CTRL_TWO, 8'h00);
        wr(atc_pkg::OFS_IRQ_MASK, 8'h00);
        wr(atc_pkg::OFS_CTRL_THREE, 8'h08);
        wr(atc_pkg::OFS_CTRL_ONE, 8'h00);
        wait_strobe;
        count_strobes(cnt);
        chk(16'(cnt), 16'h0003);
        chk(16'(irq), 16'h0000);
        wr(atc_pkg::OFS_IRQ_MASK, 8'h01);
        @(negedge clk_sys);
        chk(16'(irq), 16'h0001);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(atc_pkg::OFS_CTRL_TWO, d);
        chk(16'(d), 16'h0000);
        chk(16'(irq), 16'h0000);
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        end_of_test;
    end
endmodule
bind atc_top atc_checker #(.NUM_CHAN(NUM_CHAN), .CONV_CYCLES(CONV_CYCLES)) i_atc_checker (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe), .port_out_enable(port_out_enable),
    .pin_oe(pin_oe), .pin_in_level(pin_in_level), .port_read_data(port_read_data));
`default_nettype wire
